// ---- common/ivfs_pkg.sv ----
// Constants and types for the input-voltage fault supervisor
package ivfs_pkg;
  localparam logic [7:0] CMD_OV_FAULT_LIM = 8'h55;
  localparam logic [7:0] CMD_OV_FAULT_ACT = 8'h56;
  localparam logic [7:0] CMD_OV_WARN_LIM  = 8'h57;
  localparam logic [7:0] CMD_UV_WARN_LIM  = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT_LIM = 8'h59;
  localparam logic [7:0] CMD_UV_FAULT_ACT = 8'h5a;
  localparam logic [15:0] RST_OV_FAULT_LIM = 16'hd3a0;
  localparam logic [15:0] RST_OV_WARN_LIM  = 16'hd360;
  // 4.5 V in linear-11: mantissa 9, exponent -1
  localparam logic [15:0] RST_UV_WARN_LIM  = 16'hf809;
  localparam logic [7:0]  RST_FAULT_ACT    = 8'h80;
  localparam int ACT_MODE_HI  = 7;
  localparam int ACT_MODE_LO  = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_TIME_HI  = 2;
  localparam int ACT_TIME_LO  = 0;
  localparam logic [1:0] MODE_IGNORE  = 2'h0;
  localparam logic [1:0] MODE_DELAY   = 2'h1;
  localparam logic [1:0] MODE_DISABLE = 2'h2;
  localparam logic [1:0] MODE_FOLLOW  = 2'h3;
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // Time unit of the 3-bit count: 1 ms
  localparam int TIME_UNIT_US = 1000;
  localparam int CLK_MHZ      = 20;
  localparam int UNIT_CYCLES  = TIME_UNIT_US * CLK_MHZ;
  typedef enum logic [1:0] {IVFS_RUN, IVFS_WAIT, IVFS_OFF, IVFS_RETRY} ivfs_state_t;
endpackage

// ---- rtl/ivfs_resp.sv ----
// Fault response sequencer for one input fault
`timescale 1ns/10ps
`default_nettype none
module ivfs_resp
  import ivfs_pkg::*;
#(
  parameter int UNIT = UNIT_CYCLES
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fault,
  input  wire logic [7:0] action,
  output logic            out_off
);
  typedef struct packed {
    ivfs_state_t  st;
    logic [31:0]  tick;
    logic [2:0]   units;
    logic [2:0]   tries;
    logic         off;
  } ivfs_resp_t;
  ivfs_resp_t s_q;
  ivfs_resp_t s_d;
  logic [1:0] mode;
  logic [2:0] retry;
  logic [2:0] tcnt;
  logic       unit_end;
  assign mode     = action[ACT_MODE_HI:ACT_MODE_LO];
  assign retry    = action[ACT_RETRY_HI:ACT_RETRY_LO];
  assign tcnt     = action[ACT_TIME_HI:ACT_TIME_LO];
  assign unit_end = (s_q.tick == 32'(UNIT - 1));
  assign out_off  = s_q.off;
  always_comb
  begin
    s_d = s_q;
    s_d.tick = unit_end ? 32'h0000_0000 : s_q.tick + 32'h0000_0001;
    case (s_q.st)
      IVFS_RUN:
      begin
        s_d.off = 1'b0;
        s_d.units = 3'h0;
        s_d.tick = 32'h0000_0000;
        if (fault)
        begin
          if (mode == MODE_DELAY)
            s_d.st = IVFS_WAIT;
          else if (mode == MODE_DISABLE)
          begin
            s_d.st = IVFS_OFF;
            s_d.off = 1'b1;
          end
          else if (mode == MODE_FOLLOW)
            s_d.off = 1'b1;
          s_d.tries = retry;
        end
      end
      IVFS_WAIT:
      begin
        if (unit_end)
          s_d.units = s_q.units + 3'h1;
        if (s_q.units >= tcnt)
        begin
          s_d.st = IVFS_OFF;
          s_d.off = 1'b1;
          s_d.units = 3'h0;
          s_d.tick = 32'h0000_0000;
        end
      end
      IVFS_OFF:
      begin
        s_d.off = 1'b1;
        if (retry == RETRY_NONE)
          s_d.st = IVFS_OFF;
        else
        begin
          if (unit_end)
            s_d.units = s_q.units + 3'h1;
          if (s_q.units >= tcnt)
          begin
            s_d.st = IVFS_RETRY;
            s_d.units = 3'h0;
          end
        end
      end
      default:
      begin
        s_d.off = 1'b0;
        if (retry == RETRY_FOREVER)
          s_d.st = IVFS_RUN;
        else if (s_q.tries != 3'h0)
        begin
          s_d.tries = s_q.tries - 3'h1;
          s_d.st = IVFS_RUN;
        end
        else
        begin
          s_d.st = IVFS_OFF;
          s_d.off = 1'b1;
        end
      end
    endcase
    if (s_q.st == IVFS_RUN && mode == MODE_FOLLOW)
      s_d.off = fault;
    if (mode == MODE_IGNORE && s_q.st == IVFS_RUN)
      s_d.off = 1'b0;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{IVFS_RUN, 32'h0000_0000, 3'h0, 3'h0, 1'b0};
    else
      s_q <= s_d;
  end
endmodule
`default_nettype wire

// ---- rtl/ivfs_top.sv ----
// Input-voltage fault supervisor register bank and comparators
`timescale 1ns/10ps
`default_nettype none
module ivfs_top
  import ivfs_pkg::*;
#(
  parameter int UNIT = UNIT_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  cmd,
  input  wire logic [15:0] wr_data,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  output logic             cmd_bad,
  input  wire logic        clear_faults,
  input  wire logic [15:0] uv_fault_strap,
  input  wire logic        vin_valid,
  input  wire logic [15:0] vin_sample,
  output logic             ov_fault_flag,
  output logic             uv_fault_flag,
  output logic             ov_warn_flag,
  output logic             uv_warn_flag,
  output logic             input_flag,
  output logic             nota_flag,
  output logic             notify,
  output logic             output_off
);
  typedef struct packed {
    logic [15:0] ov_lim;
    logic [7:0]  ov_act;
    logic [15:0] ovw_lim;
    logic [15:0] uvw_lim;
    logic [15:0] uv_lim;
    logic [7:0]  uv_act;
    logic        strap_done;
    logic [15:0] rdat;
    logic        rval;
    logic        bad;
    logic        ovf;
    logic        uvf;
    logic        ovw;
    logic        uvw;
    logic        ntf;
    logic        ov_act_in;
    logic        uv_act_in;
    logic        off;
    logic        inp;
    logic        nota;
  } ivfs_top_t;
  ivfs_top_t s_q;
  ivfs_top_t s_d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic        ov_off;
  logic        uv_off;

  // Linear-11 to a common fixed point: value * 2^16, 48-bit signed
  function automatic logic signed [47:0] l11_val(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [47:0] m;
    e = w[15:11];
    m = 48'(signed'(w[10:0]));
    if (e >= 0)
      l11_val = m <<< (16 + e);
    else
      l11_val = (m <<< 16) >>> (-e);
  endfunction

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  always_comb
  begin
    logic signed [47:0] v;
    logic               hit_ov;
    logic               hit_uv;
    logic               hit_ovw;
    logic               hit_uvw;
    v = l11_val(vin_sample);
    hit_ov  = v > l11_val(s_q.ov_lim);
    hit_ovw = v > l11_val(s_q.ovw_lim);
    hit_uvw = v < l11_val(s_q.uvw_lim);
    hit_uv  = v < l11_val(s_q.uv_lim);
    s_d = s_q;
    s_d.rval = 1'b0;
    s_d.bad = 1'b0;
    s_d.ntf = 1'b0;
    if (!s_q.strap_done)
    begin
      s_d.uv_lim = uv_fault_strap;
      s_d.strap_done = 1'b1;
    end
    if (wr_en)
    begin
      if (cmd == CMD_OV_FAULT_LIM)
        s_d.ov_lim = wr_data;
      else if (cmd == CMD_OV_FAULT_ACT)
        s_d.ov_act = wr_data[7:0];
      else if (cmd == CMD_OV_WARN_LIM)
        s_d.ovw_lim = wr_data;
      else if (cmd == CMD_UV_WARN_LIM)
        s_d.uvw_lim = wr_data;
      else if (cmd == CMD_UV_FAULT_LIM)
        s_d.uv_lim = wr_data;
      else if (cmd == CMD_UV_FAULT_ACT)
        s_d.uv_act = wr_data[7:0];
      else
        s_d.bad = 1'b1;
    end
    if (rd_en)
    begin
      s_d.rval = 1'b1;
      if (cmd == CMD_OV_FAULT_LIM)
        s_d.rdat = s_q.ov_lim;
      else if (cmd == CMD_OV_FAULT_ACT)
        s_d.rdat = {8'h00, s_q.ov_act};
      else if (cmd == CMD_OV_WARN_LIM)
        s_d.rdat = s_q.ovw_lim;
      else if (cmd == CMD_UV_WARN_LIM)
        s_d.rdat = s_q.uvw_lim;
      else if (cmd == CMD_UV_FAULT_LIM)
        s_d.rdat = s_q.uv_lim;
      else if (cmd == CMD_UV_FAULT_ACT)
        s_d.rdat = {8'h00, s_q.uv_act};
      else
      begin
        s_d.rdat = 16'h0000;
        s_d.bad = 1'b1;
      end
    end
    // Fault conditions feeding the response sequencers: OV follows each sample, UV holds until a sample is not below the UV warn limit
    if (vin_valid)
    begin
      s_d.ov_act_in = hit_ov;
      if (hit_uv)
        s_d.uv_act_in = 1'b1;
      else if (!hit_uvw)
        s_d.uv_act_in = 1'b0;
    end
    if (clear_faults)
    begin
      s_d.ovf = 1'b0;
      s_d.uvf = 1'b0;
      s_d.ovw = 1'b0;
      s_d.uvw = 1'b0;
    end
    if (vin_valid)
    begin
      if (hit_ov)
        s_d.ovf = 1'b1;
      if (hit_uv)
        s_d.uvf = 1'b1;
      if (hit_ovw)
        s_d.ovw = 1'b1;
      if (hit_uvw)
        s_d.uvw = 1'b1;
      if ((hit_ov && !s_q.ovf) || (hit_uv && !s_q.uvf) ||
          (hit_ovw && !s_q.ovw) || (hit_uvw && !s_q.uvw))
        s_d.ntf = 1'b1;
    end
    s_d.off = ov_off | uv_off;
    s_d.inp = s_d.ovf | s_d.uvf | s_d.ovw | s_d.uvw;
    s_d.nota = s_d.ovw | s_d.uvw;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{RST_OV_FAULT_LIM, RST_FAULT_ACT, RST_OV_WARN_LIM,
               RST_UV_WARN_LIM, 16'h0000, RST_FAULT_ACT, 1'b0,
               16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
               1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    else
      s_q <= s_d;
  end

  ivfs_resp #(.UNIT(UNIT)) u_ov_resp (
    .clk     (clk),
    .rst_n   (rst_n),
    .fault   (s_q.ov_act_in),
    .action  (s_q.ov_act),
    .out_off (ov_off)
  );
  ivfs_resp #(.UNIT(UNIT)) u_uv_resp (
    .clk     (clk),
    .rst_n   (rst_n),
    .fault   (s_q.uv_act_in),
    .action  (s_q.uv_act),
    .out_off (uv_off)
  );

  assign rd_data       = s_q.rdat;
  assign rd_valid      = s_q.rval;
  assign cmd_bad       = s_q.bad;
  assign ov_fault_flag = s_q.ovf;
  assign uv_fault_flag = s_q.uvf;
  assign ov_warn_flag  = s_q.ovw;
  assign uv_warn_flag  = s_q.uvw;
  assign input_flag    = s_q.inp;
  assign nota_flag     = s_q.nota;
  assign notify        = s_q.ntf;
  assign output_off    = s_q.off;
endmodule
`default_nettype wire

// ---- tb/ivfs_chk.sv ----
// Port assertions for the input-voltage fault supervisor
`timescale 1ns/10ps
`default_nettype none
module ivfs_chk
  import ivfs_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] cmd,
  input wire logic       rd_valid,
  input wire logic       cmd_bad,
  input wire logic       clear_faults,
  input wire logic       vin_valid,
  input wire logic       ov_fault_flag,
  input wire logic       uv_fault_flag,
  input wire logic       ov_warn_flag,
  input wire logic       uv_warn_flag,
  input wire logic       input_flag,
  input wire logic       nota_flag,
  input wire logic       notify
);
  logic known;
  assign known = (cmd >= CMD_OV_FAULT_LIM) && (cmd <= CMD_UV_FAULT_ACT);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (rd_en && known |=> rd_valid && !cmd_bad)
    else $error("known read not answered");
  a_bad_cmd: assert property ((rd_en || wr_en) && !known |=> cmd_bad)
    else $error("unknown command not refused");
  a_bad_quiet: assert property (!rd_en && !wr_en |=> !cmd_bad)
    else $error("refusal without request");
  a_read_cause: assert property (rd_valid |-> $past(rd_en))
    else $error("read answer without read");
  a_input_sum: assert property (input_flag == (ov_fault_flag ||
    uv_fault_flag || ov_warn_flag || uv_warn_flag))
    else $error("input summary wrong");
  a_nota_sum: assert property (nota_flag == (ov_warn_flag || uv_warn_flag))
    else $error("warning summary wrong");
  a_fault_sticky: assert property (ov_fault_flag && !clear_faults |=> ov_fault_flag)
    else $error("fault flag dropped");
  a_flag_clear: assert property (clear_faults && !vin_valid |=>
    !ov_fault_flag && !ov_warn_flag && !uv_warn_flag)
    else $error("flags not cleared");
  a_notify_cause: assert property (notify |-> input_flag)
    else $error("notify without flag");
endmodule
bind ivfs_top ivfs_chk i_ivfs_chk (
  .clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
  .cmd(cmd), .rd_valid(rd_valid), .cmd_bad(cmd_bad),
  .clear_faults(clear_faults), .vin_valid(vin_valid),
  .ov_fault_flag(ov_fault_flag), .uv_fault_flag(uv_fault_flag),
  .ov_warn_flag(ov_warn_flag), .uv_warn_flag(uv_warn_flag),
  .input_flag(input_flag), .nota_flag(nota_flag), .notify(notify)
);
`default_nettype wire

// ---- tb/ivfs_host.sv ----
// Host model issuing command reads and writes
`timescale 1ns/10ps
`default_nettype none
module ivfs_host
(
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  input  wire logic        cmd_bad,
  output logic             wr_en,
  output logic             rd_en,
  output logic [7:0]       cmd,
  output logic [15:0]      wr_data
);
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    cmd = 8'h00;
    wr_data = 16'h0000;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    cmd <= c;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    cmd <= ~c;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d,
                    output logic b);
    @(posedge clk);
    rd_en <= 1'b1;
    cmd <= c;
    @(posedge clk);
    rd_en <= 1'b0;
    cmd <= ~c;
    #1;
    d = rd_data;
    b = cmd_bad;
  endtask
endmodule
`default_nettype wire

// ---- tb/ivfs_top_tb.sv ----
// Self-checking bench for the input-voltage fault supervisor
`timescale 1ns/10ps
`default_nettype none
module ivfs_top_tb;
  import ivfs_pkg::*;
  localparam logic [15:0] S_STRAP = 16'hd0c0;
  localparam logic [15:0] S_WARN  = 16'hd384;
  localparam logic [15:0] S_OVF   = 16'hd3c0;
  localparam logic [15:0] S_OK    = 16'hd200;
  localparam logic [15:0] S_UVF   = 16'hd0a0;
  localparam logic [15:0] S_MID   = 16'hd100;
  localparam logic [95:0] RST_TAB = {8'h00, RST_FAULT_ACT, S_STRAP,
    RST_UV_WARN_LIM, RST_OV_WARN_LIM, 8'h00, RST_FAULT_ACT,
    RST_OV_FAULT_LIM};
  localparam logic [95:0] WR_TAB = 96'h0041_d0d0_f80a_d340_00c9_d3b0;
  logic        clk;
  logic        reset_n;
  logic        clear_faults;
  logic        vin_valid;
  logic [15:0] vin_sample;
  logic        wr_en;
  logic        rd_en;
  logic        cmd_bad;
  logic [7:0]  cmd;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [7:0]  fl;
  int          err_total;
  int          n_compared;
  ivfs_top #(.UNIT(4)) i_ivfs_top (
    .clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
    .cmd(cmd), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(),
    .cmd_bad(cmd_bad), .clear_faults(clear_faults),
    .uv_fault_strap(S_STRAP), .vin_valid(vin_valid),
    .vin_sample(vin_sample), .ov_fault_flag(fl[7]),
    .uv_fault_flag(fl[6]), .ov_warn_flag(fl[5]), .uv_warn_flag(fl[4]),
    .input_flag(fl[3]), .nota_flag(fl[2]), .notify(fl[1]),
    .output_off(fl[0])
  );
  ivfs_host i_ivfs_host (
    .clk(clk), .rd_data(rd_data), .cmd_bad(cmd_bad), .wr_en(wr_en),
    .rd_en(rd_en), .cmd(cmd), .wr_data(wr_data)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("compared %0d wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic fchk(input logic [6:0] e);
    chk("flags", {9'h000, e}, {9'h000, fl[7:1]});
  endtask
  task automatic wait_off(input logic e, input int n);
    for (int i = 0; i < n && fl[0] !== e; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("output_off", {15'h0000, e}, {15'h0000, fl[0]});
    if (fl[0] !== e)
      report_and_stop();
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic vin(input logic [15:0] s);
    @(posedge clk);
    vin_valid <= 1'b1;
    vin_sample <= s;
    @(posedge clk);
    vin_valid <= 1'b0;
    vin_sample <= ~s;
    #1;
  endtask
  task automatic t_regs();
    logic [15:0] d;
    logic        b;
    for (int i = 0; i < 6; i++)
    begin
      i_ivfs_host.rd(CMD_OV_FAULT_LIM + 8'(i), d, b);
      chk("reset", RST_TAB[16*i +: 16], d);
    end
    for (int i = 0; i < 6; i++)
      i_ivfs_host.wr(CMD_OV_FAULT_LIM + 8'(i), WR_TAB[16*i +: 16]);
    i_ivfs_host.wr(8'h54, 16'h1234);
    for (int i = 0; i < 6; i++)
    begin
      i_ivfs_host.rd(CMD_OV_FAULT_LIM + 8'(i), d, b);
      chk("readback", WR_TAB[16*i +: 16], d);
    end
    i_ivfs_host.rd(8'h5b, d, b);
    chk("bad_data", 16'h0000, d);
    chk("bad_flag", 16'h0001, {15'h0000, b});
  endtask
  task automatic t_warn();
    vin(S_WARN);
    fchk(7'h17);
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    #1;
    fchk(7'h00);
  endtask
  task automatic t_fault(input logic [7:0] act);
    do_reset();
    i_ivfs_host.wr(CMD_OV_FAULT_ACT, {8'h00, act});
    vin(S_OVF);
    fchk(7'h57);
  endtask
  initial
  begin
    err_total = 0;
    n_compared = 0;
    reset_n = 1'b0;
    clear_faults = 1'b0;
    vin_valid = 1'b0;
    vin_sample = S_OK;
    do_reset();
    t_regs();
    do_reset();
    t_warn();
    t_fault(RST_FAULT_ACT);
    wait_off(1'b1, 3);
    vin(S_OK);
    repeat (20) @(posedge clk);
    wait_off(1'b1, 0);
    fchk(7'h56);
    t_fault(8'h00);
    repeat (20) @(posedge clk);
    wait_off(1'b0, 0);
    t_fault(8'h42);
    repeat (2) @(posedge clk);
    wait_off(1'b0, 0);
    wait_off(1'b1, 30);
    t_fault(8'h89);
    wait_off(1'b1, 3);
    wait_off(1'b0, 30);
    wait_off(1'b1, 3);
    do_reset();
    i_ivfs_host.wr(CMD_UV_FAULT_ACT, 16'h00c0);
    vin(S_UVF);
    fchk(7'h2f);
    wait_off(1'b1, 3);
    vin(S_MID);
    repeat (10) @(posedge clk);
    wait_off(1'b1, 0);
    vin(S_OK);
    wait_off(1'b0, 5);
    report_and_stop();
  end
endmodule
`default_nettype wire
